// ===== dv/psd_decoder_monitor.sv
// Purpose: port assertions of the strobe command decoder
// Assumes: straps change only while reset is low
// Notes:   bound onto psd_decoder by the bench
`timescale 1ns/10ps
module psd_decoder_monitor
  import psd_pkg::*;
#(
  parameter int SPOKES_P = 96
) (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // host pins and straps
  input wire logic                  select_n,
  input wire logic [11:0]           data_n,
  input wire logic                  strobe_carriage_n,
  input wire logic                  strobe_wheel_n,
  input wire logic                  ready_n,
  input wire logic                  ready_oe,
  input wire psd_pkg::psd_variant_t variant,
  input wire logic                  ribbon_single_step_jumper,
  input wire logic                  ribbon_host_control_jumper,
  // commands
  input wire logic                  carriage_go,
  input wire logic [9:0]            carriage_steps,
  input wire logic                  carriage_dir,
  input wire logic                  carriage_half,
  input wire logic                  settle_extend,
  input wire logic                  paper_go,
  input wire logic                  type_wheel_go,
  input wire logic [6:0]            type_wheel_spoke,
  input wire logic [6:0]            type_wheel_steps,
  input wire logic                  ribbon_two_step
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ready low means idle and enabled, so a fresh strobe must be taken
  a_carriage_take: assert property (
    $fell(strobe_carriage_n) && !select_n && ready_oe && !ready_n |=> carriage_go)
    else $error("carriage strobe not taken");
  a_carriage_word: assert property (
    carriage_go |-> {carriage_half, carriage_dir, carriage_steps} == ~$past(data_n))
    else $error("carriage fields differ from strobed word");
  a_go_cause: assert property (
    carriage_go |-> $past(strobe_carriage_n) == 1'b0 && $past(select_n) == 1'b0)
    else $error("carriage command without selected strobe");
  a_wheel_latency: assert property (
    $fell(strobe_wheel_n) && !select_n && ready_oe && !ready_n |-> ##3 type_wheel_go)
    else $error("type wheel command late or missing");
  a_abs_spoke: assert property (
    type_wheel_go && variant == PSD_VAR_C && ribbon_host_control_jumper
    |-> type_wheel_spoke == ~$past(data_n[6:0], 3))
    else $error("absolute spoke differs from word");
  a_short_path: assert property (
    type_wheel_go |-> type_wheel_steps <= SPOKES_P / 2)
    else $error("wheel rotation longer than half a turn");
  a_single_step: assert property (
    type_wheel_go && variant != PSD_VAR_C && ribbon_single_step_jumper |-> !ribbon_two_step)
    else $error("two step ribbon despite single step jumper");
  a_settle_map: assert property (
    ready_oe |-> settle_extend == (variant == PSD_VAR_C && ribbon_single_step_jumper))
    else $error("settle extension wrong for straps");
  a_busy_status: assert property (
    (carriage_go || paper_go || type_wheel_go) && ready_oe |-> ready_n ##1 ready_n)
    else $error("ready shown while operation runs");
  c_carriage: cover property (carriage_go);
  c_paper: cover property (paper_go);
  c_wheel_c: cover property (type_wheel_go && variant == PSD_VAR_C);
endmodule : psd_decoder_monitor

// ===== dv/psd_decoder_test.sv
// Purpose: self-checking bench of psd_decoder
// Assumes: bench is bus master and mechanism
// Notes:   random words from a fixed seed
`timescale 1ns/10ps
module psd_decoder_test;
  import psd_pkg::*;
  localparam int SP = 96;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, w;
  logic [31:0]  s_axi_wdata = 32'h0000_0000, d;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0]   dn = 3'h0, straps = 3'h0;
  logic [1:0]   r;
  logic [9:0]   ent;
  logic [6:0]   pos;
  logic [4:0]   cfgs [9] = '{5'h00, 5'h06, 5'h02, 5'h01, 5'h09, 5'h0A, 5'h13, 5'h11, 5'h14};
  psd_variant_t variant = PSD_VAR_A;
  wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]    s_axi_bresp, s_axi_rresp;
  wire [31:0]   s_axi_rdata;
  wire          select_n, strobe_carriage_n, strobe_paper_n, strobe_wheel_n, strobe_option_n;
  wire [11:0]   data_n;
  wire          ready_n, ready_oe, carriage_go, carriage_dir, carriage_half, settle_extend;
  wire          paper_go, paper_dir, type_wheel_go, type_wheel_cw, ribbon_two_step;
  wire [9:0]    carriage_steps, paper_steps;
  wire [6:0]    type_wheel_spoke, type_wheel_steps;
  wire [2:0]    hammer_energy, gos = {type_wheel_go, paper_go, carriage_go};
  wire [18:0]   wheel_out = {ribbon_two_step, hammer_energy, type_wheel_cw, type_wheel_steps,
                             type_wheel_spoke};
  int           failures = 0, comparisons = 0, cycles = 0, n_go = 0, k;
  psd_host_model host_u (.aclk, .select_n, .data_n,
    .strobe_n({strobe_option_n, strobe_wheel_n, strobe_paper_n, strobe_carriage_n}));
  psd_decoder #(.SPOKES_P(SP)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .select_n, .data_n, .strobe_carriage_n,
    .strobe_paper_n, .strobe_wheel_n, .strobe_option_n, .ready_n, .ready_oe, .variant,
    .ribbon_single_step_jumper(straps[2]), .ribbon_host_control_jumper(straps[1]),
    .hammer_energy_jumper(straps[0]), .carriage_go, .carriage_steps, .carriage_dir,
    .carriage_half, .settle_extend, .carriage_done(dn[0]), .paper_go, .paper_steps,
    .paper_dir, .paper_done(dn[1]), .type_wheel_go, .type_wheel_spoke, .type_wheel_steps,
    .type_wheel_cw, .hammer_energy, .ribbon_two_step, .type_wheel_done(dn[2]));
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (aresetn && gos !== 3'h0) n_go <= n_go + 1;
    if (cycles >= 20000) begin
      failures = failures + 1;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // straps only move under reset, they are static otherwise
  task automatic rst(input logic [4:0] cf);
    @(posedge aclk);
    aresetn <= 1'b0;
    variant <= psd_variant_t'(cf[4:3]);
    straps  <= cf[2:0];
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : rst
  // handshakes sampled at the falling edge, acted on at the next rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    logic aw, wh, ar, fin;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    fin = 1'b0;
    while (!fin) begin
      @(negedge aclk);
      aw  = s_axi_awvalid & s_axi_awready;
      wh  = s_axi_wvalid & s_axi_wready;
      ar  = s_axi_arvalid & s_axi_arready;
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      r   = wr ? s_axi_bresp : s_axi_rresp;
      d   = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (fin) s_axi_bready <= 1'b0;
      if (fin) s_axi_rready <= 1'b0;
    end
  endtask : xfer
  task automatic cmd(input int kk, input logic [11:0] ww);
    int i;
    fork
      host_u.issue(kk, ww);
    join_none
    for (i = 0; i < 20 && gos[kk] !== 1'b1; i++) @(negedge aclk);
    check(i < 20, 1'b1);
  endtask : cmd
  task automatic done(input int kk);
    check(ready_n, 1'b1);
    @(posedge aclk);
    dn <= 3'h1 << kk;
    @(posedge aclk);
    dn <= 3'h0;
    @(negedge aclk);
    check(ready_n, 1'b0);
  endtask : done
  function automatic logic [18:0] exp_wheel(input logic [4:0] cf, input logic [11:0] ww,
                                            input logic [9:0] en, input logic [6:0] p);
    logic c, absl, host, hr, two, cw;
    logic [6:0] tgt;
    int fwd;
    c    = cf[4:3] == 2'h2;
    absl = (c && cf[1]) || (!c && cf[0] && ww[7]);
    host = (!c && cf[0]) || (c && (cf[1] || cf[0]));
    hr   = (cf[4:3] == 2'h0 && cf[1]) || (c && (cf[1] || cf[0]));
    two  = (!c && cf[2]) ? 1'b0 : (hr ? ww[11] : 1'b1);
    tgt  = absl ? ww[6:0] : en[6:0];
    fwd  = (int'(tgt) + SP - int'(p)) % SP;
    cw   = fwd <= SP / 2;
    return {two, host ? ww[10:8] : en[9:7], cw, 7'(cw ? fwd : SP - fwd), tgt};
  endfunction : exp_wheel
  initial begin
    void'($urandom(32'h879823e5));
    rst(5'h00);
    xfer(1'b0, ADDR_CTRL, 32'h0);
    check(d, CTRL_RESET);
    xfer(1'b0, 12'h100, 32'h0);
    check({r, d}, {RESP_SLVERR, 32'h0});
    xfer(1'b1, 12'h104, 32'hFFFF_FFFF);
    check(r, RESP_SLVERR);
    $display("test registers done");
    xfer(1'b1, ADDR_CTRL, 32'h0);
    host_u.issue(0, 12'h0FF);
    host_u.select(1'b1);
    xfer(1'b1, ADDR_CTRL, 32'h1);
    host_u.issue(2, 12'h001);
    repeat (5) @(negedge aclk);
    check({n_go[30:0], ready_oe}, 32'h0);
    host_u.select(1'b0);
    repeat (2) @(negedge aclk);
    check({ready_oe, ready_n}, 2'b10);
    $display("test refused strobes done");
    for (int i = 0; i < 10; i++) begin
      w = (i < 2) ? 12'hFFF : (i < 4) ? 12'h000 : 12'($urandom);
      k = i % 2;
      cmd(k, w);
      if (k == 0) check({carriage_half, carriage_dir, carriage_steps}, w);
      else check({paper_dir, paper_steps}, w[10:0]);
      done(k);
    end
    $display("test motion done");
    for (int c = 0; c < 9; c++) begin
      rst(cfgs[c]);
      check(settle_extend, cfgs[c][4:3] == 2'h2 && cfgs[c][2]);
      for (int t = 0; t < 3; t++) begin
        w      = 12'($urandom);
        w[6:0] = 7'($urandom % SP);
        ent    = {3'($urandom), 7'($urandom % SP)};
        pos    = 7'($urandom % SP);
        xfer(1'b1, ADDR_TABLE + {w[6:0], 2'b00}, {22'h0, ent});
        xfer(1'b1, ADDR_POS, {25'h0, pos});
        cmd(2, w);
        check(wheel_out, exp_wheel(cfgs[c], w, ent, pos));
        done(2);
      end
      $display("test wheel config %0d done", c);
    end
    end_sim();
  end
endmodule : psd_decoder_test
bind psd_decoder psd_decoder_monitor #(.SPOKES_P(SPOKES_P)) mon_u (
  .aclk, .aresetn, .select_n, .data_n, .strobe_carriage_n, .strobe_wheel_n, .ready_n,
  .ready_oe, .variant, .ribbon_single_step_jumper, .ribbon_host_control_jumper,
  .carriage_go, .carriage_steps, .carriage_dir, .carriage_half, .settle_extend, .paper_go,
  .type_wheel_go, .type_wheel_spoke, .type_wheel_steps, .ribbon_two_step);

// ===== dv/psd_host_model.sv
// Purpose: host printer controller driving select, strobes and data
// Assumes: one command at a time, called from the bench
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/10ps
module psd_host_model (
  // clock
  input wire logic aclk,
  // host pins
  output logic        select_n,
  output logic [11:0] data_n,
  output logic [3:0]  strobe_n
);
  initial begin
    select_n = 1'b0;
    data_n   = 12'hFFF;
    strobe_n = 4'hF;
  end
  task automatic select(input logic s);
    @(posedge aclk);
    select_n <= s;
  endtask : select
  // k: 0 carriage, 1 paper, 2 type wheel, 3 option
  task automatic issue(input int k, input logic [11:0] w);
    @(posedge aclk);
    data_n   <= ~w;
    strobe_n <= ~(4'h1 << k);
    // two edges of hold, so the latch edge never sees a moving word
    repeat (2) @(posedge aclk);
    strobe_n <= 4'hF;
    data_n   <= w;
  endtask : issue
endmodule : psd_host_model

// ===== verilog/psd_decoder.sv
// Purpose: strobe command decoder of a daisy-wheel printer host port
// Assumes: host pins synchronous to aclk; configuration straps static
// Notes:   mechanism reports completion on the *_done inputs
`timescale 1ns/10ps
module psd_decoder
  import psd_pkg::*;
#(
  parameter int SPOKES_P = psd_pkg::SPOKES
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite slave
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // host pins, active low except ready_oe, which is high while ready_n is driven
  input  wire logic                         select_n,
  input  wire logic [psd_pkg::DATA_W-1:0]   data_n,
  input  wire logic                         strobe_carriage_n,
  input  wire logic                         strobe_paper_n,
  input  wire logic                         strobe_wheel_n,
  input  wire logic                         strobe_option_n,
  output logic                              ready_n,
  output logic                              ready_oe,
  // configuration straps
  input  wire psd_pkg::psd_variant_t        variant,
  input  wire logic                         ribbon_single_step_jumper,
  input  wire logic                         ribbon_host_control_jumper,
  input  wire logic                         hammer_energy_jumper,
  // carriage command
  output logic                              carriage_go,
  output logic [psd_pkg::MAG_W-1:0]         carriage_steps,
  output logic                              carriage_dir,
  output logic                              carriage_half,
  output logic                              settle_extend,
  input  wire logic                         carriage_done,
  // paper command
  output logic                              paper_go,
  output logic [psd_pkg::MAG_W-1:0]         paper_steps,
  output logic                              paper_dir,
  input  wire logic                         paper_done,
  // type wheel command
  output logic                              type_wheel_go,
  output logic [psd_pkg::CODE_W-1:0]        type_wheel_spoke,
  output logic [psd_pkg::CODE_W-1:0]        type_wheel_steps,
  output logic                              type_wheel_cw,
  output logic [psd_pkg::ENERGY_W-1:0]      hammer_energy,
  output logic                              ribbon_two_step,
  input  wire logic                         type_wheel_done
);
  import psd_pkg::*;

  if (SPOKES_P < 2 || SPOKES_P > 128) begin : g_bad_spokes
    $error("psd_decoder: spoke count out of range");
  end

  function automatic logic fell(input logic now_n, input logic was_n);
    fell = !now_n && was_n;
  endfunction : fell

  function automatic logic in_table(input logic [11:0] a);
    in_table = a[11:9] == ADDR_TABLE[11:9]; // 128 words on a 512-byte boundary, no carry out
  endfunction : in_table

  // straps, caught once after reset release
  psd_variant_t cfg_var;
  logic         cfg_j1;
  logic         cfg_j2;
  logic         cfg_jh;
  logic         cfg_taken;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_taken <= 1'b0;
      cfg_var   <= PSD_VAR_A;
      cfg_j1    <= 1'b0;
      cfg_j2    <= 1'b0;
      cfg_jh    <= 1'b0;
    end else if (!cfg_taken) begin
      cfg_taken <= 1'b1;
      cfg_var   <= variant;
      cfg_j1    <= ribbon_single_step_jumper;
      cfg_j2    <= ribbon_host_control_jumper;
      cfg_jh    <= hammer_energy_jumper;
    end
  end

  // mode decode
  wire var_ab      = cfg_var == PSD_VAR_A || cfg_var == PSD_VAR_B;
  wire var_c       = cfg_var == PSD_VAR_C;
  wire c_host_all  = var_c && cfg_j2;
  wire c_host_en   = var_c && cfg_jh && !cfg_j2;
  wire ab_energy   = var_ab && cfg_jh;
  wire a_host_rib  = cfg_var == PSD_VAR_A && cfg_j2 && !cfg_j1;
  wire host_energy = ab_energy || c_host_all || c_host_en;
  wire host_ribbon = a_host_rib || c_host_all || c_host_en;
  assign settle_extend = var_c && cfg_j1;

  // host strobes and word; logic one is a low pin
  wire [DATA_W-1:0] word     = ~data_n;
  wire              selected = !select_n && cfg_taken;
  logic             car_was_n;
  logic             pap_was_n;
  logic             whl_was_n;
  logic             car_busy;
  logic             pap_busy;
  logic             whl_busy;
  logic [31:0]      ctrl;
  wire              live     = selected && ctrl[0];
  wire car_fire = live && fell(strobe_carriage_n, car_was_n) && !car_busy;
  wire pap_fire = live && fell(strobe_paper_n, pap_was_n) && !pap_busy;
  wire whl_fire = live && fell(strobe_wheel_n, whl_was_n) && !whl_busy;

  // ready is only driven while selected; low while busy
  wire ready = !(car_busy || pap_busy || whl_busy) && ctrl[0];
  assign ready_oe = selected;
  assign ready_n  = !ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      car_was_n <= 1'b1;
      pap_was_n <= 1'b1;
      whl_was_n <= 1'b1;
    end else begin
      car_was_n <= strobe_carriage_n;
      pap_was_n <= strobe_paper_n;
      whl_was_n <= strobe_wheel_n;
    end
  end

  // carriage and paper: parameters latched in the strobe cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carriage_go    <= 1'b0;
      carriage_steps <= '0;
      carriage_dir   <= 1'b0;
      carriage_half  <= 1'b0;
      car_busy       <= 1'b0;
    end else begin
      carriage_go <= car_fire;
      if (car_fire) begin
        carriage_steps <= word[MAG_W-1:0];
        carriage_dir   <= word[DIR_BIT];
        carriage_half  <= word[TOP_BIT];
        car_busy       <= 1'b1;
      end else if (carriage_done) begin
        car_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paper_go    <= 1'b0;
      paper_steps <= '0;
      paper_dir   <= 1'b0;
      pap_busy    <= 1'b0;
    end else begin
      paper_go <= pap_fire;
      if (pap_fire) begin
        paper_steps <= word[MAG_W-1:0];
        paper_dir   <= word[DIR_BIT];
        pap_busy    <= 1'b1;
      end else if (paper_done) begin
        pap_busy <= 1'b0;
      end
    end
  end

  // type wheel: held word, table lookup, then path
  psd_table_if #(.AW(CODE_W), .DW(ENTRY_W)) tbl ();
  psd_wheel_state_t  wstate;
  psd_wheel_state_t  next_wstate;
  logic [DATA_W-1:0] whl_word;
  logic [CODE_W-1:0] wheel_pos;
  logic              whl_absolute;
  logic              whl_host_e;
  logic              axi_wr_go;
  logic [11:0]       awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  // line 8 high means character code, so absolute is a logic one
  wire               absolute  = c_host_all || (ab_energy && whl_word[SEL_BIT]);
  wire [CODE_W-1:0]  tbl_spoke = tbl.rdata[CODE_W-1:0];
  wire [CODE_W-1:0]  target    = absolute ? whl_word[CODE_W-1:0] : tbl_spoke;
  wire [ENERGY_W-1:0] energy   = host_energy ? whl_word[ENERGY_LSB +: ENERGY_W]
                                             : tbl.rdata[ENTRY_W-1:CODE_W];
  wire               two_step  = (var_ab && cfg_j1)  ? 1'b0
                               : host_ribbon ? whl_word[TOP_BIT]
                               : 1'b1;
  wire [CODE_W-1:0]  path_steps;
  wire               path_cw;

  psd_wheel_path #(.SPOKES(SPOKES_P)) u_path (
    .cur    (wheel_pos),
    .target (target),
    .steps  (path_steps),
    .cw     (path_cw)
  );

  psd_table_mem #(.AW(CODE_W), .DW(ENTRY_W)) u_table (
    .aclk (aclk),
    .port (tbl.mem)
  );

  wire tbl_hit = in_table(awaddr_q);
  assign tbl.re    = wstate == PSD_W_LOOK;
  assign tbl.raddr = whl_word[CODE_W-1:0];
  assign tbl.we    = axi_wr_go && tbl_hit && wstrb_q[0];
  assign tbl.waddr = awaddr_q[CODE_W+1:2];
  assign tbl.wdata = wdata_q[ENTRY_W-1:0];

  always_comb begin
    next_wstate = wstate;
    unique case (wstate)
      PSD_W_IDLE:  if (whl_fire) next_wstate = PSD_W_LOOK;
      PSD_W_LOOK:  next_wstate = PSD_W_FETCH;
      PSD_W_FETCH: next_wstate = PSD_W_IDLE;
      default:     next_wstate = PSD_W_IDLE;
    endcase
  end

  logic pos_wr;
  assign pos_wr = axi_wr_go && awaddr_q == ADDR_POS && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate           <= PSD_W_IDLE;
      whl_word         <= '0;
      whl_busy         <= 1'b0;
      type_wheel_go    <= 1'b0;
      type_wheel_spoke <= '0;
      type_wheel_steps <= '0;
      type_wheel_cw    <= 1'b0;
      hammer_energy    <= '0;
      ribbon_two_step  <= 1'b0;
      whl_absolute     <= 1'b0;
      whl_host_e       <= 1'b0;
      wheel_pos        <= '0;
    end else begin
      wstate        <= next_wstate;
      type_wheel_go <= 1'b0;
      if (whl_fire) begin
        whl_word <= word;
        whl_busy <= 1'b1;
      end else if (type_wheel_done && wstate == PSD_W_IDLE) begin
        whl_busy <= 1'b0;
      end
      if (wstate == PSD_W_FETCH) begin
        type_wheel_go    <= 1'b1;
        type_wheel_spoke <= target;
        type_wheel_steps <= path_steps;
        type_wheel_cw    <= path_cw;
        hammer_energy    <= energy;
        ribbon_two_step  <= two_step;
        whl_absolute     <= absolute;
        whl_host_e       <= host_energy;
        wheel_pos        <= target;
      end else if (pos_wr) begin
        wheel_pos <= wdata_q[CODE_W-1:0];
      end
    end
  end

  // axi4-lite write: address and data taken in either order
  logic aw_held;
  logic w_held;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign axi_wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire   wr_mapped     = awaddr_q == ADDR_CTRL || awaddr_q == ADDR_POS || tbl_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl         <= CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (axi_wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == ADDR_CTRL && wstrb_q[0]) ctrl[0] <= wdata_q[0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  wire [11:0] ar = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] rd_status = {23'h0, !strobe_option_n, settle_extend, cfg_jh, cfg_j2, cfg_j1,
                           cfg_var, ready, selected};
  wire [31:0] rd_car = {15'h0, car_busy, 4'h0, carriage_half, carriage_dir, carriage_steps};
  wire [31:0] rd_pap = {15'h0, pap_busy, 5'h0, paper_dir, paper_steps};
  wire [31:0] rd_whl = {7'h0, whl_busy, 2'h0, whl_absolute, ribbon_two_step, whl_host_e,
                        hammer_energy, type_wheel_cw, type_wheel_steps, 1'b0,
                        type_wheel_spoke};
  wire        rd_tbl = in_table(ar);
  wire        rd_map = ar == ADDR_STATUS || ar == ADDR_CARRIAGE || ar == ADDR_PAPER ||
                       ar == ADDR_WHEEL || ar == ADDR_CTRL || ar == ADDR_POS || rd_tbl;
  wire [31:0] rd_mux = ar == ADDR_STATUS   ? rd_status
                     : ar == ADDR_CARRIAGE ? rd_car
                     : ar == ADDR_PAPER    ? rd_pap
                     : ar == ADDR_WHEEL    ? rd_whl
                     : ar == ADDR_CTRL     ? ctrl
                     : ar == ADDR_POS      ? {25'h0, wheel_pos}
                     : 32'h0;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : psd_decoder

// ===== verilog/psd_pkg.sv
// Purpose: shared constants and types of the strobe command decoder
// Assumes: AXI4-Lite register window with 32-bit data
// Notes:   register offsets are byte addresses
package psd_pkg;
  // host word layout
  localparam int DATA_W     = 12;
  localparam int MAG_W      = 10;
  localparam int CODE_W     = 7;
  localparam int ENERGY_W   = 3;
  localparam int DIR_BIT    = 10;
  localparam int TOP_BIT    = 11;
  localparam int SEL_BIT    = 7;
  localparam int ENERGY_LSB = 8;
  // table entry layout: spoke in the low bits, energy above
  localparam int ENTRY_W    = CODE_W + ENERGY_W;
  localparam int SPOKES     = 96;
  // register map
  localparam logic [11:0] ADDR_STATUS   = 12'h000;
  localparam logic [11:0] ADDR_CARRIAGE = 12'h004;
  localparam logic [11:0] ADDR_PAPER    = 12'h008;
  localparam logic [11:0] ADDR_WHEEL    = 12'h00C;
  localparam logic [11:0] ADDR_CTRL     = 12'h010;
  localparam logic [11:0] ADDR_POS      = 12'h014;
  localparam logic [11:0] ADDR_TABLE    = 12'h200;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    PSD_VAR_A = 2'h0,
    PSD_VAR_B = 2'h1,
    PSD_VAR_C = 2'h2
  } psd_variant_t;
  typedef enum logic [2:0] {
    PSD_W_IDLE  = 3'h1,
    PSD_W_LOOK  = 3'h2,
    PSD_W_FETCH = 3'h4
  } psd_wheel_state_t;
endpackage : psd_pkg

// ===== verilog/psd_table_if.sv
// Purpose: port of the character table memory
// Assumes: one write port, one read port, same clock
// Notes:   read data return one cycle after re
`timescale 1ns/10ps
interface psd_table_if #(parameter int AW = 7, parameter int DW = 10);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic          re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
  modport user (output we, waddr, wdata, re, raddr, input rdata);
endinterface : psd_table_if

// ===== verilog/psd_table_mem.sv
// Purpose: character code to spoke and hammer energy table
// Assumes: software loads it before printing
// Notes:   contents are undefined after power up
`timescale 1ns/10ps
module psd_table_mem #(
  parameter int AW = 7,
  parameter int DW = 10
) (
  // clock
  input wire logic  aclk,
  // table port
  psd_table_if.mem  port
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  if (AW < 1 || DW < 1) begin : g_bad_geometry
    $error("psd_table_mem: bad geometry");
  end

  always_ff @(posedge aclk) begin
    if (port.we) store[port.waddr] <= port.wdata;
  end

  always_ff @(posedge aclk) begin
    if (port.re) port.rdata <= store[port.raddr];
  end
endmodule : psd_table_mem

// ===== verilog/psd_wheel_path.sv
// Purpose: shortest rotation from current spoke to target spoke
// Assumes: both positions below the spoke count
// Notes:   a tie at half a turn goes clockwise
`timescale 1ns/10ps
module psd_wheel_path #(
  parameter int SPOKES = 96
) (
  // positions
  input  wire logic [6:0] cur,
  input  wire logic [6:0] target,
  // path
  output logic      [6:0] steps,
  output logic            cw
);
  localparam logic [7:0] N    = 8'(SPOKES);
  localparam logic [7:0] HALF = 8'(SPOKES / 2);

  if (SPOKES < 2 || SPOKES > 128) begin : g_bad_spokes
    $error("psd_wheel_path: spoke count out of range");
  end

  wire [7:0] cur_w  = {1'b0, cur};
  wire [7:0] tgt_w  = {1'b0, target};
  wire [7:0] fwd    = (tgt_w >= cur_w) ? tgt_w - cur_w : tgt_w + N - cur_w;
  wire       go_cw  = fwd <= HALF;
  wire [7:0] back   = N - fwd;

  assign cw    = go_cw;
  assign steps = go_cw ? fwd[6:0] : back[6:0];
endmodule : psd_wheel_path
